// >>> hw/rtu_params.svh
`ifndef RTU_PARAMS_SVH
`define RTU_PARAMS_SVH
`define CLK_HZ        10000000
`define RATE_0        9600
`define RATE_1        19200
`define RATE_2        38400
`define RATE_3        57600
`define GAP_BITS      39
`define OFF_STATUS    8'h00
`define OFF_RXDATA    8'h04
`define OFF_TXDATA    8'h08
`define OFF_CONFIG    8'h0C
`define ST_RXVALID    0
`define ST_FRAMEEND   1
`define ST_CRCOK      2
`define ST_OVERRUN    3
`define ST_TXBUSY     4
`define ST_OFFLINE    5
`define ST_REPLYOK    6
`define ST_INFRAME    7
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'hA001
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// >>> hw/rtu_pkg.sv
package rtu_pkg;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} rx_st_t;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} tx_st_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [1:0] baud;
		logic       par_en;
	} cfg_t;
	typedef struct packed {
		logic        s1, s2, s3, rx_lvl;
		cfg_t        swa, swb, swc, cfg;
		rx_st_t      rx_st;
		logic [15:0] rx_cnt;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic        rx_par, char_err;
		logic [15:0] idle_cnt;
		logic        in_frame, match, bad;
		logic [15:0] crc;
		logic [7:0]  rx_data;
		logic        rx_valid, frame_end, crc_ok, overrun, reply_ok;
		tx_st_t      tx_st;
		logic [15:0] tx_cnt;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_sh;
		logic        tx_par, txd, de;
		logic        aw_held, w_held, wstrb0;
		logic [7:0]  awaddr, wdata, araddr;
		logic        awready, wready, bvalid, arready, rvalid;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
	} st_t;
endpackage

// >>> hw/rtu_slave.sv
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rtu_params.svh"
module rtu_slave (
	input  wire logic        aclk,          // System clock, 10 MHz
	input  wire logic        aresetn,       // Synchronous reset, active low
	input  wire logic [31:0] s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte enables
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [31:0] s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	input  wire logic        rx_pin,        // Serial line receive
	output logic             tx_pin,        // Serial line transmit
	output logic             tx_drive_en,   // Line driver enable, high while sending
	input  wire logic [7:0]  addr_sw,       // Address switches, bit n weighs 2**n
	input  wire logic [1:0]  baud_sw,       // Bit rate switches
	input  wire logic        parity_sw      // High selects even parity
);
	rtu_pkg::st_t s, n;
	logic [15:0] bit_cyc, half_cyc, gap_cyc;
	logic        rx_tick, tx_tick, byte_done, err, fin, hit;
	logic [7:0]  rdoff;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_comb begin
		case (s.cfg.baud)
			2'h0:    bit_cyc = 16'(`CLK_HZ / `RATE_0);
			2'h1:    bit_cyc = 16'(`CLK_HZ / `RATE_1);
			2'h2:    bit_cyc = 16'(`CLK_HZ / `RATE_2);
			default: bit_cyc = 16'(`CLK_HZ / `RATE_3);
		endcase
		half_cyc = bit_cyc >> 1;
		gap_cyc = 16'(32'(bit_cyc) * `GAP_BITS);
	end

	always_comb begin
		n = s;
		err = 1'b0;
		byte_done = 1'b0;
		fin = 1'b0;
		hit = 1'b0;
		rdoff = 8'h00;
		// Three-stage synchronisers; a level is taken once stages two and three agree.
		n.s1 = rx_pin;
		n.s2 = s.s1;
		n.s3 = s.s2;
		if (s.s2 == s.s3) begin
			n.rx_lvl = s.s3;
		end
		n.swa = '{addr: addr_sw, baud: baud_sw, par_en: parity_sw};
		n.swb = s.swa;
		n.swc = s.swb;
		if (s.swb == s.swc) begin
			n.cfg = s.swc;
		end

		rx_tick = (s.rx_cnt == bit_cyc - 16'h0001);
		n.rx_cnt = rx_tick ? 16'h0000 : s.rx_cnt + 16'h0001;
		case (s.rx_st)
			rtu_pkg::RX_IDLE: begin
				n.rx_cnt = 16'h0000;
				if (!s.rx_lvl) begin
					n.rx_st = rtu_pkg::RX_START;
					n.char_err = 1'b0;
					n.rx_par = 1'b0;
				end
			end
			rtu_pkg::RX_START: begin
				if (s.rx_cnt == half_cyc) begin
					n.rx_cnt = 16'h0000;
					n.rx_bit = 3'h0;
					n.rx_st = s.rx_lvl ? rtu_pkg::RX_IDLE : rtu_pkg::RX_DATA;
				end
			end
			rtu_pkg::RX_DATA: begin
				if (rx_tick) begin
					n.rx_sh = {s.rx_lvl, s.rx_sh[7:1]};
					n.rx_par = s.rx_par ^ s.rx_lvl;
					n.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == 3'h7) begin
						n.rx_st = s.cfg.par_en ? rtu_pkg::RX_PAR : rtu_pkg::RX_STOP;
					end
				end
			end
			rtu_pkg::RX_PAR: begin
				if (rx_tick) begin
					n.char_err = s.char_err | (s.rx_par ^ s.rx_lvl);
					n.rx_st = rtu_pkg::RX_STOP;
				end
			end
			rtu_pkg::RX_STOP: begin
				// Only the first stop bit is checked, so a second one simply reads as idle line.
				if (rx_tick) begin
					err = s.char_err | ~s.rx_lvl;
					byte_done = 1'b1;
					n.rx_st = rtu_pkg::RX_IDLE;
				end
			end
			default: n.rx_st = rtu_pkg::RX_IDLE;
		endcase

		// Saturating at the gap keeps the count from wrapping when the rate switches move.
		n.idle_cnt = (s.rx_st == rtu_pkg::RX_IDLE && s.idle_cnt < gap_cyc) ? s.idle_cnt + 16'h0001 :
			(s.rx_st == rtu_pkg::RX_IDLE ? s.idle_cnt : 16'h0000);
		if (byte_done) begin
			if (!s.in_frame) begin
				hit = (s.cfg.addr != 8'h00) && (s.rx_sh == s.cfg.addr);
				n.in_frame = 1'b1;
				n.match = hit;
				n.bad = err;
				n.reply_ok = 1'b0;
				n.crc = crc_step(`CRC_INIT, s.rx_sh);
			end else begin
				hit = s.match;
				n.bad = s.bad | err;
				n.crc = crc_step(s.crc, s.rx_sh);
			end
		end
		if (s.in_frame && s.idle_cnt >= gap_cyc) begin
			fin = 1'b1;
			n.in_frame = 1'b0;
			if (s.match) begin
				n.frame_end = 1'b1;
				n.crc_ok = (s.crc == 16'h0000) && !s.bad;
				n.reply_ok = (s.crc == 16'h0000) && !s.bad && (s.cfg.addr != 8'h00);
			end
		end

		// AXI4-Lite write: address and data taken in either order, response once both are held.
		if (s.awready && s_axi_awvalid) begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr[7:0];
		end
		if (s.wready && s_axi_wvalid) begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `RESP_OKAY;
			if (s.awaddr == `OFF_STATUS) begin
				// A frame closing in the same cycle keeps its flag set.
				if (s.wstrb0 && s.wdata[`ST_FRAMEEND] && !(fin && s.match)) begin
					n.frame_end = 1'b0;
				end
				if (s.wstrb0 && s.wdata[`ST_OVERRUN]) begin
					n.overrun = 1'b0;
				end
			end else if (s.awaddr == `OFF_TXDATA) begin
				// A byte is sent only after a frame for us and never while off-line or busy.
				if (s.wstrb0 && s.tx_st == rtu_pkg::TX_IDLE && s.reply_ok && !s.in_frame &&
					s.cfg.addr != 8'h00) begin
					n.tx_st = rtu_pkg::TX_START;
					n.tx_sh = s.wdata;
					n.tx_par = ^s.wdata;
					n.tx_cnt = 16'h0000;
					n.txd = 1'b0;
					n.de = 1'b1;
				end
			end else if (s.awaddr != `OFF_RXDATA && s.awaddr != `OFF_CONFIG) begin
				n.bresp = `RESP_SLVERR;
			end
		end

		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s.arready && s_axi_arvalid) begin
			rdoff = s_axi_araddr[7:0];
			n.rvalid = 1'b1;
			n.rresp = `RESP_OKAY;
			n.rdata = 32'h0000_0000;
			if (rdoff == `OFF_STATUS) begin
				n.rdata[7:0] = {s.in_frame, s.reply_ok, s.cfg.addr == 8'h00, s.tx_st != rtu_pkg::TX_IDLE,
					s.overrun, s.crc_ok, s.frame_end, s.rx_valid};
			end else if (rdoff == `OFF_RXDATA) begin
				n.rdata[7:0] = s.rx_data;
				n.rx_valid = 1'b0;
			end else if (rdoff == `OFF_CONFIG) begin
				n.rdata[10:0] = s.cfg;
			end else if (rdoff != `OFF_TXDATA) begin
				n.rresp = `RESP_SLVERR;
			end
		end
		// A new byte wins over a read that clears the flag in the same cycle.
		if (byte_done && hit) begin
			n.rx_data = s.rx_sh;
			n.rx_valid = 1'b1;
			if (s.rx_valid) begin
				n.overrun = 1'b1;
			end
		end

		tx_tick = (s.tx_cnt == bit_cyc - 16'h0001);
		if (s.tx_st != rtu_pkg::TX_IDLE) begin
			n.tx_cnt = tx_tick ? 16'h0000 : s.tx_cnt + 16'h0001;
		end
		case (s.tx_st)
			rtu_pkg::TX_IDLE: ;
			rtu_pkg::TX_START: begin
				if (tx_tick) begin
					n.tx_st = rtu_pkg::TX_DATA;
					n.tx_bit = 3'h0;
					n.txd = s.tx_sh[0];
				end
			end
			rtu_pkg::TX_DATA: begin
				if (tx_tick) begin
					n.tx_sh = s.tx_sh >> 1;
					n.tx_bit = s.tx_bit + 3'h1;
					n.txd = s.tx_sh[1];
					if (s.tx_bit == 3'h7) begin
						n.tx_st = s.cfg.par_en ? rtu_pkg::TX_PAR : rtu_pkg::TX_STOP;
						n.txd = s.cfg.par_en ? s.tx_par : 1'b1;
						n.tx_bit = 3'h0;
					end
				end
			end
			rtu_pkg::TX_PAR: begin
				if (tx_tick) begin
					n.tx_st = rtu_pkg::TX_STOP;
					n.txd = 1'b1;
					n.tx_bit = 3'h1;
				end
			end
			rtu_pkg::TX_STOP: begin
				// Two stop bits without parity keep every character eleven bits long.
				if (tx_tick) begin
					n.tx_bit = s.tx_bit + 3'h1;
					if (s.tx_bit == 3'h1) begin
						n.tx_st = rtu_pkg::TX_IDLE;
						n.de = 1'b0;
					end
				end
			end
			default: n.tx_st = rtu_pkg::TX_IDLE;
		endcase

		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.s1 <= 1'b1;
			s.s2 <= 1'b1;
			s.s3 <= 1'b1;
			s.rx_lvl <= 1'b1;
			s.txd <= 1'b1;
			s.rx_st <= rtu_pkg::RX_IDLE;
			s.tx_st <= rtu_pkg::TX_IDLE;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign tx_pin        = s.txd;
	assign tx_drive_en   = s.de;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_offline_silent: assert property ($rose(s.de) |-> $past(s.cfg.addr) != 8'h00)
		else $error("transmission started while off-line");
	a_reply_needs_match: assert property ($rose(s.reply_ok) |-> s.match && $past(s.in_frame))
		else $error("reply enabled for a frame not addressed here");
	a_switch_address: assert property ((s.swb == s.swc) |=> s.cfg == $past(s.swc))
		else $error("settled switches not taken as configuration");
	a_frame_address: assert property (byte_done && !s.in_frame |=>
		s.match == ($past(s.cfg.addr) != 8'h00 && $past(s.rx_sh) == $past(s.cfg.addr)))
		else $error("frame address compare wrong");
	a_one_stop: assert property (s.rx_st == rtu_pkg::RX_STOP && rx_tick |=> s.rx_st == rtu_pkg::RX_IDLE)
		else $error("receiver waited beyond first stop bit");
	a_tx_parity: assert property (s.tx_st == rtu_pkg::TX_PAR |-> s.txd == s.tx_par && s.cfg.par_en)
		else $error("parity bit wrong or sent with parity off");
	a_bit_length: assert property (s.tx_st != rtu_pkg::TX_IDLE |-> s.tx_cnt < bit_cyc)
		else $error("transmit bit counter overran bit time");
	a_gap_ends_frame: assert property (s.in_frame && s.idle_cnt == gap_cyc |=> !s.in_frame)
		else $error("silent gap did not close the frame");
endmodule

// >>> tb/rtu_master_model.sv
`timescale 1ns/1ps
module rtu_master_model #(
	parameter int BIT = 173
) (
	input  wire logic aclk,   // System clock
	input  wire logic par_en, // Even parity in use
	input  wire logic tx_pin, // Line from the slave
	input  wire logic de,     // Slave line driver enable
	output logic      rx_pin  // Line to the slave
);
	// A released line rests at the idle mark level held by the bus biasing.
	wire logic seen = de ? tx_pin : 1'b1;
	initial rx_pin = 1'b1;
	task automatic bit_out(input logic v);
		rx_pin <= v;
		repeat (BIT) @(posedge aclk);
	endtask
	// Sends one character at the rate set by BIT and the parity the switches select.
	task automatic send(input logic [7:0] b, input logic two_stop);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(b[i]);
		end
		if (par_en) begin
			bit_out(^b);
		end
		bit_out(1'b1);
		if (two_stop) begin
			bit_out(1'b1);
		end
	endtask
	// Samples each bit in its middle; ok is low on timeout, bad parity or bad stop.
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (seen !== 1'b0 && n < 20000) begin
			@(posedge aclk);
			n++;
		end
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			b[i] = seen;
		end
		ok = n < 20000;
		if (par_en) begin
			repeat (BIT) @(posedge aclk);
			ok = ok && seen === ^b;
		end
		repeat (BIT) @(posedge aclk);
		ok = ok && seen === 1'b1;
	endtask
endmodule

// >>> tb/rtu_slave_test.sv
`timescale 1ns/1ps
module rtu_slave_test;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, line, parity_sw, ok;
	logic        awready, wready, bvalid, arready, rvalid, tx_pin, tx_drive_en;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [1:0]  bresp, rresp, rs, baud_sw;
	logic [7:0]  addr_sw, rb;
	logic [7:0]  fr [4];
	logic [15:0] c;
	int          failures, cmp_count;
	int          cyc = 0;
	always #50 aclk = ~aclk;
	rtu_slave dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(line), .tx_pin(tx_pin),
		.tx_drive_en(tx_drive_en), .addr_sw(addr_sw), .baud_sw(baud_sw), .parity_sw(parity_sw));
	rtu_master_model #(.BIT(173)) model_u (.aclk(aclk), .par_en(parity_sw), .tx_pin(tx_pin),
		.de(tx_drive_en), .rx_pin(line));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= {24'h00, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= {24'h00, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	function automatic logic [15:0] crc_upd(input logic [15:0] cin, input logic [7:0] b);
		logic [15:0] x;
		x = cin ^ {8'h00, b};
		for (int i = 0; i < 8; i++) x = x[0] ? (x >> 1) ^ 16'hA001 : x >> 1;
		return x;
	endfunction
	// Sends the frame in fr with alternating stop counts and checks every byte and the closing status.
	task automatic frame_rx;
		for (int i = 0; i < 4; i++) begin
			model_u.send(fr[i], i[0]);
			axr(8'h04, rd, rs);
			chk(rd, {24'h00, fr[i]});
		end
		repeat (7000) @(posedge aclk);
		axr(8'h00, rd, rs);
		chk(rd, 32'h00000046);
	endtask
	// Writes one reply byte and checks the character and the driver enable on the line.
	task automatic tx_check;
		fork
			axw(8'h08, 32'h0000005A, rs);
			model_u.recv(rb, ok);
			begin
				repeat (20) @(posedge aclk);
				chk({31'h0, tx_drive_en}, 32'h1);
			end
		join
		chk({24'h0, rb}, 32'h5A);
		chk({31'h0, ok}, 32'h1);
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 80000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		addr_sw = 8'h29;
		baud_sw = 2'h3;
		parity_sw = 1'b1;
		failures = 0;
		cmp_count = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		axr(8'h0C, rd, rs);
		chk(rd, 32'h0000014F);
		addr_sw <= 8'hFF;
		baud_sw <= 2'h1;
		repeat (6) @(posedge aclk);
		axr(8'h0C, rd, rs);
		chk(rd, 32'h000007FB);
		addr_sw <= 8'h29;
		baud_sw <= 2'h3;
		axr(8'h10, rd, rs);
		chk({30'h0, rs}, 32'h2);
		repeat (6) @(posedge aclk);
		c = crc_upd(crc_upd(16'hFFFF, 8'h29), 8'h03);
		fr = '{8'h29, 8'h03, c[7:0], c[15:8]};
		frame_rx();
		addr_sw <= 8'h00;
		repeat (6) @(posedge aclk);
		axr(8'h00, rd, rs);
		chk({31'h0, rd[5]}, 32'h1);
		axw(8'h08, 32'h0000005A, rs);
		repeat (300) @(posedge aclk);
		chk({31'h0, tx_drive_en}, 32'h0);
		addr_sw <= 8'h29;
		repeat (6) @(posedge aclk);
		tx_check();
		axw(8'h00, 32'h00000002, rs);
		chk({30'h0, rs}, 32'h0);
		model_u.send(8'h05, 1'b0);
		model_u.send(8'h03, 1'b1);
		repeat (7000) @(posedge aclk);
		axr(8'h00, rd, rs);
		chk(rd & 32'h3, 32'h0);
		parity_sw <= 1'b0;
		repeat (6) @(posedge aclk);
		frame_rx();
		tx_check();
		end_sim();
	end
endmodule
